// ===== rtl/pvc_pkg.sv
// constants, field layouts and carrier types of the pump and calibration config block
// assumes a single 100 MHz pclk domain and an APB master with 8-bit byte addresses
`default_nettype none
package pvc_pkg;
   localparam int unsigned APB_AW = 8;
   localparam int unsigned APB_DW = 32;
   localparam int unsigned REG_W  = 24;

   // register indices; the byte address is four times the index
   localparam logic [5:0] IDX_CHARGE_PUMP = 6'h09;
   localparam logic [5:0] IDX_VCO_CAL     = 6'h0A;
   localparam logic [5:0] IDX_STATUS      = 6'h10;
   localparam logic [7:0] ADDR_CHARGE_PUMP = {IDX_CHARGE_PUMP, 2'b00};
   localparam logic [7:0] ADDR_VCO_CAL     = {IDX_VCO_CAL, 2'b00};
   localparam logic [7:0] ADDR_STATUS      = {IDX_STATUS, 2'b00};

   localparam logic [23:0] RST_CHARGE_PUMP = 24'h403264;
   localparam logic [23:0] RST_VCO_CAL     = 24'h002205;

   // current weights in microamps per code step
   localparam logic [11:0] PUMP_STEP_UA   = 12'h014;
   localparam logic [9:0]  OFFSET_STEP_UA = 10'h005;

   // last count of each reference divider ratio
   localparam logic [4:0] DIV1_LAST  = 5'h00;
   localparam logic [4:0] DIV4_LAST  = 5'h03;
   localparam logic [4:0] DIV16_LAST = 5'h0F;
   localparam logic [4:0] DIV32_LAST = 5'h1F;

   localparam logic [7:0] SUPPR_CNT_MAX = 8'hFF;

   typedef enum logic [1:0] {
      REF_DIV_1  = 2'b00,
      REF_DIV_4  = 2'b01,
      REF_DIV_16 = 2'b10,
      REF_DIV_32 = 2'b11
   } pvc_ref_div_t;

   typedef enum logic {
      WIN_IDLE    = 1'b0,
      WIN_MEASURE = 1'b1
   } pvc_win_state_t;

   typedef struct packed {
      logic       rsvd_23;
      logic       ofs_dn_en;
      logic       ofs_up_en;
      logic [6:0] ofs_mag;
      logic [6:0] up_code;
      logic [6:0] dn_code;
   } pvc_pump_cfg_t;

   typedef struct packed {
      logic [8:0]   rsvd_23_15;
      pvc_ref_div_t clk_sel;
      logic         no_vco_serial;
      logic         cal_disable;
      logic         force_curve;
      logic [6:0]   rsvd_9_3;
      logic [2:0]   window_code;
   } pvc_cal_cfg_t;

   typedef struct packed {
      logic       window_busy;
      logic       window_done_seen;
      logic [7:0] suppressed_cnt;
   } pvc_status_t;

   typedef struct packed {
      logic [11:0] down_ua;
      logic [11:0] up_ua;
      logic [9:0]  offset_ua;
   } pvc_pump_ua_t;
endpackage
`default_nettype wire

// ===== rtl/pvc_ref_divider.sv
// divides the reference enable down to the calibration engine enable
// assumes ref_tick is a one-cycle pulse made by logic on pclk
`default_nettype none
module pvc_ref_divider
   import pvc_pkg::*;
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ref_tick,
   input  wire pvc_ref_div_t div_sel,
   output logic              cal_tick
);
   logic [4:0] cnt_ff;
   logic [4:0] nxt_cnt;
   logic [4:0] last;

   always_comb begin
      unique case (div_sel)
         REF_DIV_1:  last = DIV1_LAST;
         REF_DIV_4:  last = DIV4_LAST;
         REF_DIV_16: last = DIV16_LAST;
         REF_DIV_32: last = DIV32_LAST;
      endcase
   end

   // a ratio change mid-count finishes at the new last value, no stray fast tick
   always_comb begin
      nxt_cnt = cnt_ff;
      if (ref_tick) begin
         if (cnt_ff >= last) begin
            nxt_cnt = 5'h00;
         end else begin
            nxt_cnt = cnt_ff + 5'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 5'h00;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign cal_tick = ref_tick && (cnt_ff >= last);
endmodule
`default_nettype wire

// ===== rtl/pvc_window_timer.sv
// tuning voltage measurement window, 2**code reference cycles long
// assumes start and ref_tick are pulses from logic on pclk
`default_nettype none
module pvc_window_timer
   import pvc_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       start,
   input  wire logic       ref_tick,
   input  wire logic [2:0] code,
   output logic            busy,
   output logic            done
);
   pvc_win_state_t state_ff;
   pvc_win_state_t nxt_state;
   logic [8:0]     cnt_ff;
   logic [8:0]     nxt_cnt;
   logic [8:0]     target;
   logic           done_ff;
   logic           nxt_done;

   assign target = 9'h001 << code;

   // a start while measuring restarts the window
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_done  = 1'b0;
      unique case (state_ff)
         WIN_IDLE: begin
            if (start) begin
               nxt_state = WIN_MEASURE;
               nxt_cnt   = 9'h000;
            end
         end
         WIN_MEASURE: begin
            if (start) begin
               nxt_cnt = 9'h000;
            end else if (ref_tick) begin
               nxt_cnt = cnt_ff + 9'h001;
               if (cnt_ff + 9'h001 >= target) begin
                  nxt_state = WIN_IDLE;
                  nxt_done  = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= WIN_IDLE;
         cnt_ff   <= 9'h000;
         done_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         done_ff  <= nxt_done;
      end
   end

   assign busy = (state_ff == WIN_MEASURE);
   assign done = done_ff;
endmodule
`default_nettype wire

// ===== rtl/pvc_cfg_regs.sv
// charge pump and VCO calibration configuration registers behind an APB slave
// assumes ref_tick, cal_start and vco_access_wr come from logic on pclk
// the status word at byte 0x40 is local to this block: suppressed trigger count, done flag, busy
//
// Register access over APB was chosen for this implementation.
`default_nettype none
module pvc_cfg_regs
   import pvc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ref_tick,
   input  wire logic        cal_start,
   input  wire logic        vco_access_wr,
   output pvc_pump_cfg_t    pump_cfg,
   output pvc_pump_ua_t     pump_ua,
   output logic             cp_offset_up_en,
   output logic             cp_offset_dn_en,
   output logic             cal_enable,
   output logic             cal_force_curve,
   output logic             cal_tick,
   output logic             window_busy,
   output logic             window_done,
   output logic             vco_serial_transfer
);
   pvc_pump_cfg_t pump_ff;
   pvc_pump_cfg_t nxt_pump;
   pvc_cal_cfg_t  cal_ff;
   pvc_cal_cfg_t  nxt_cal;
   logic          done_seen_ff;
   logic          nxt_done_seen;
   logic [7:0]    suppr_cnt_ff;
   logic [7:0]    nxt_suppr_cnt;
   logic [31:0]   rdata_ff;
   logic [31:0]   nxt_rdata;
   logic          err_ff;
   logic          nxt_err;
   pvc_pump_ua_t  ua_ff;
   pvc_pump_ua_t  nxt_ua;
   logic          serial_ff;
   logic          nxt_serial;
   pvc_status_t   status;
   logic          setup;
   logic          access;
   logic          wr_en;
   logic          hit_pump;
   logic          hit_cal;
   logic          hit_status;
   logic          win_start;
   logic [31:0]   wmask;
   logic [31:0]   rd_word;
   logic          addr_hit;
   logic          wr_pump;
   logic          wr_cal;
   pvc_status_t   status_clr;
   logic          clr_cnt;
   logic          clr_done;
   logic          suppress_hit;

   // bus decode
   assign setup      = psel && !penable;
   assign access     = psel && penable;
   assign hit_pump   = (paddr == ADDR_CHARGE_PUMP);
   assign hit_cal    = (paddr == ADDR_VCO_CAL);
   assign hit_status = (paddr == ADDR_STATUS);
   assign addr_hit   = hit_pump || hit_cal || hit_status;

   // zero wait states: every access phase completes in its first cycle
   assign pready  = access;
   assign pslverr = access && err_ff;
   assign prdata  = rdata_ff;

   // an erroring write changes nothing
   assign wr_en = access && pwrite && !err_ff;
   // writes land only at the access edge, never in the setup cycle
   assign wr_pump = wr_en && hit_pump;
   assign wr_cal  = wr_en && hit_cal;

   // byte strobes expanded into a bit mask
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         assign wmask[g*8 +: 8] = {8{pstrb[g]}};
      end
   endgenerate

   assign status.window_busy      = window_busy;
   assign status.window_done_seen = done_seen_ff;
   assign status.suppressed_cnt   = suppr_cnt_ff;

   // read word chosen from the address and pwrite; unmapped and write cycles give zero
   always_comb begin
      rd_word = 32'h0000_0000;
      if (!pwrite) begin
         if (hit_pump) begin
            rd_word = {8'h00, pump_ff};
         end else if (hit_cal) begin
            rd_word = {8'h00, cal_ff};
         end else if (hit_status) begin
            rd_word = {22'h00_0000, status};
         end
      end
   end

   // read data is caught in the setup cycle so that the data output
   // leaves a flip-flop; the access phase then answers at once
   always_comb begin
      nxt_rdata = rdata_ff;
      if (setup) begin
         nxt_rdata = rd_word;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_ff <= 32'h0000_0000;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // decode error decided at setup too, so pslverr needs no decode later
   always_comb begin
      nxt_err = err_ff;
      if (setup) begin
         nxt_err = !addr_hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_ff <= 1'b0;
      end else begin
         err_ff <= nxt_err;
      end
   end

   // configuration registers
   // every bit is stored as written, reserved ones too, so software that
   // writes back what it read keeps the recommended reserved values
   always_comb begin
      nxt_pump = pump_ff;
      if (wr_pump) begin
         nxt_pump = (pump_ff & ~wmask[23:0]) | (pwdata[23:0] & wmask[23:0]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pump_ff <= RST_CHARGE_PUMP;
      end else begin
         pump_ff <= nxt_pump;
      end
   end

   always_comb begin
      nxt_cal = cal_ff;
      if (wr_cal) begin
         nxt_cal = (cal_ff & ~wmask[23:0]) | (pwdata[23:0] & wmask[23:0]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_ff <= RST_VCO_CAL;
      end else begin
         cal_ff <= nxt_cal;
      end
   end

   // pump currents
   // codes scaled to microamps for the analog pump trim; one cycle behind
   // the register, which the slow analog settling easily hides
   always_comb begin
      nxt_ua.down_ua   = {5'h00, pump_ff.dn_code} * PUMP_STEP_UA;
      nxt_ua.up_ua     = {5'h00, pump_ff.up_code} * PUMP_STEP_UA;
      nxt_ua.offset_ua = {3'h0, pump_ff.ofs_mag} * OFFSET_STEP_UA;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ua_ff <= '0;
      end else begin
         ua_ff <= nxt_ua;
      end
   end

   assign pump_cfg = pump_ff;
   assign pump_ua  = ua_ff;

   // direction enables go out as stored; choosing them is up to software
   assign cp_offset_up_en = pump_ff.ofs_up_en;
   assign cp_offset_dn_en = pump_ff.ofs_dn_en;

   // calibration engine controls
   assign cal_enable      = !cal_ff.cal_disable;
   assign cal_force_curve = cal_ff.force_curve;

   // a disabled calibration never opens a measurement window
   assign win_start = cal_start && !cal_ff.cal_disable;

   // the divider cannot check the 50 MHz ceiling: it only sees enables
   pvc_ref_divider u_ref_divider (
      .pclk     (pclk),
      .presetn  (presetn),
      .ref_tick (ref_tick),
      .div_sel  (cal_ff.clk_sel),
      .cal_tick (cal_tick)
   );

   pvc_window_timer u_window_timer (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (win_start),
      .ref_tick (ref_tick),
      .code     (cal_ff.window_code),
      .busy     (window_busy),
      .done     (window_done)
   );

   // VCO serial transfer trigger and status
   // status clears act only on the byte lanes that are strobed
   assign status_clr   = pwdata[9:0] & wmask[9:0];
   assign clr_cnt      = wr_en && hit_status && (status_clr.suppressed_cnt != 8'h00);
   assign clr_done     = wr_en && hit_status && status_clr.window_done_seen;
   assign suppress_hit = vco_access_wr && cal_ff.no_vco_serial;

   // the trigger leaves a flip-flop so the VCO side sees a clean strobe
   always_comb begin
      nxt_serial = vco_access_wr && !cal_ff.no_vco_serial;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_ff <= 1'b0;
      end else begin
         serial_ff <= nxt_serial;
      end
   end

   // a suppressed trigger is counted, saturating, so software can see that
   // writes to the VCO access register went nowhere; a trigger in the
   // clearing cycle counts from zero instead of being lost
   always_comb begin
      nxt_suppr_cnt = suppr_cnt_ff;
      if (clr_cnt) begin
         nxt_suppr_cnt = 8'h00;
      end
      if (suppress_hit && (nxt_suppr_cnt != SUPPR_CNT_MAX)) begin
         nxt_suppr_cnt = nxt_suppr_cnt + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         suppr_cnt_ff <= 8'h00;
      end else begin
         suppr_cnt_ff <= nxt_suppr_cnt;
      end
   end

   // a window that ends in the clearing cycle stays recorded
   always_comb begin
      nxt_done_seen = done_seen_ff;
      if (clr_done) begin
         nxt_done_seen = 1'b0;
      end
      if (window_done) begin
         nxt_done_seen = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_seen_ff <= 1'b0;
      end else begin
         done_seen_ff <= nxt_done_seen;
      end
   end

   assign vco_serial_transfer = serial_ff;
endmodule
`default_nettype wire

// ===== test/pvc_cfg_props.sv
// assertions on the ports of the pump and calibration config block
// assumes one pclk domain with async active-low presetn
`default_nettype none
module pvc_cfg_props
   import pvc_pkg::*;
(
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pready,
   input wire logic          pslverr,
   input wire logic          ref_tick,
   input wire logic          cal_start,
   input wire logic          vco_access_wr,
   input wire pvc_pump_cfg_t pump_cfg,
   input wire pvc_pump_ua_t  pump_ua,
   input wire logic          cp_offset_up_en,
   input wire logic          cp_offset_dn_en,
   input wire logic          cal_enable,
   input wire logic          cal_tick,
   input wire logic          window_busy,
   input wire logic          window_done,
   input wire logic          vco_serial_transfer
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // currents lag the register by one cycle, so wait until reset values have passed
   logic [1:0] age_ff;
   logic [1:0] nxt_age;
   always_comb begin
      nxt_age = (age_ff == 2'h3) ? age_ff : age_ff + 2'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) age_ff <= 2'h0;
      else age_ff <= nxt_age;
   end
   property p_ready; pready == (psel && penable); endproperty
   property p_err; pslverr |-> pready; endproperty
   property p_dn; age_ff == 2'h3 |-> pump_ua.down_ua == $past(pump_cfg.dn_code) * 20; endproperty
   property p_up; age_ff == 2'h3 |-> pump_ua.up_ua == $past(pump_cfg.up_code) * 20; endproperty
   property p_ofs; age_ff == 2'h3 |-> pump_ua.offset_ua == $past(pump_cfg.ofs_mag) * 5; endproperty
   property p_upen; cp_offset_up_en == pump_cfg.ofs_up_en; endproperty
   property p_dnen; cp_offset_dn_en == pump_cfg.ofs_dn_en; endproperty
   property p_rst; $rose(presetn) |-> pump_cfg == RST_CHARGE_PUMP; endproperty
   property p_start; cal_start && cal_enable |=> window_busy; endproperty
   property p_dis; cal_start && !cal_enable && !window_busy |=> !window_busy; endproperty
   property p_done; window_done |-> !window_busy && $past(window_busy); endproperty
   property p_vco; vco_serial_transfer |-> $past(vco_access_wr); endproperty
   property p_tick; cal_tick |-> ref_tick; endproperty
   a_ready: assert property (p_ready) else $error("pready not psel and penable");
   a_err: assert property (p_err) else $error("pslverr outside access");
   a_dn: assert property (p_dn) else $error("down current wrong");
   a_up: assert property (p_up) else $error("up current wrong");
   a_ofs: assert property (p_ofs) else $error("offset current wrong");
   a_upen: assert property (p_upen) else $error("offset up enable wrong");
   a_dnen: assert property (p_dnen) else $error("offset down enable wrong");
   a_rst: assert property (p_rst) else $error("pump reset value wrong");
   a_start: assert property (p_start) else $error("window not started");
   a_dis: assert property (p_dis) else $error("window ran while disabled");
   a_done: assert property (p_done) else $error("done without busy");
   a_vco: assert property (p_vco) else $error("stray vco transfer");
   a_tick: assert property (p_tick) else $error("cal tick without ref tick");
   c_done: cover property (window_done);
   c_vco: cover property (vco_serial_transfer);
   c_err: cover property (pslverr);
endmodule
bind pvc_cfg_regs pvc_cfg_props u_props (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .ref_tick, .cal_start, .vco_access_wr, .pump_cfg, .pump_ua, .cp_offset_up_en,
   .cp_offset_dn_en, .cal_enable, .cal_tick, .window_busy, .window_done, .vco_serial_transfer);
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the pump and calibration config block
// assumes the design answers APB with pready in the first access cycle or later
`default_nettype none
module testbench
   import pvc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic          ref_tick, cal_start, vco_access_wr;
   logic [7:0]    paddr;
   logic [31:0]   pwdata, prdata, rd, d;
   logic [3:0]    pstrb;
   logic          er;
   pvc_pump_cfg_t pump_cfg;
   pvc_pump_ua_t  pump_ua;
   logic          cp_offset_up_en, cp_offset_dn_en, cal_enable, cal_force_curve;
   logic          cal_tick, window_busy, window_done, vco_serial_transfer;
   logic [23:0]   pump_m, cal_m;
   int            fail_count, n_compared, cyc, n_xfer, n_ctick, k, m;
   int            ratio[4] = '{1, 4, 16, 32};
   pvc_cfg_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .ref_tick, .cal_start, .vco_access_wr, .pump_cfg,
      .pump_ua, .cp_offset_up_en, .cp_offset_dn_en, .cal_enable, .cal_force_curve,
      .cal_tick, .window_busy, .window_done, .vco_serial_transfer);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // pulses are counted mid-cycle so reads at the rising edge never race the count
   always @(negedge pclk) begin
      if (vco_serial_transfer === 1'b1) n_xfer++;
      if (cal_tick === 1'b1) n_ctick++;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 20000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic cmp(input logic [35:0] g, input logic [35:0] e);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   function automatic logic mp(input logic [7:0] a);
      return a == ADDR_CHARGE_PUMP || a == ADDR_VCO_CAL || a == ADDR_STATUS;
   endfunction
   function automatic logic [23:0] mrg(input logic [23:0] o, input logic [31:0] v,
                                       input logic [3:0] s);
      for (int i = 0; i < 3; i++) if (s[i]) o[8*i+:8] = v[8*i+:8];
      return o;
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
                      input logic [3:0] s);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
      apb(1'b1, a, v, s);
      if (a == ADDR_CHARGE_PUMP) pump_m = mrg(pump_m, v, s);
      if (a == ADDR_VCO_CAL) cal_m = mrg(cal_m, v, s);
      cmp(er, !mp(a));
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 4'h0);
      cmp(rd, e);
      cmp(er, !mp(a));
   endtask
   // one reference tick per two pclk cycles keeps the divided clock at 50 MHz at most
   task automatic tick();
      ref_tick <= 1'b1;
      @(posedge pclk);
      ref_tick <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic chk_rst();
      pump_m = RST_CHARGE_PUMP;
      cal_m = RST_VCO_CAL;
      rdchk(ADDR_CHARGE_PUMP, {8'h00, pump_m});
      rdchk(ADDR_VCO_CAL, {8'h00, cal_m});
      cmp(cal_enable, 1'b1);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, ref_tick, cal_start, vco_access_wr} = 7'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
      {fail_count, n_compared, cyc, n_xfer, n_ctick} = '0;
      rd = $urandom(8);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk_rst();
      wr(8'h30, $urandom, 4'hF);
      rdchk(8'h30, 32'h0);
      for (int i = 0; i < 10; i++) begin
         d = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $urandom;
         wr(ADDR_CHARGE_PUMP, d, (i < 4) ? 4'hF : 4'($urandom));
         rdchk(ADDR_CHARGE_PUMP, {8'h00, pump_m});
         @(posedge pclk);
         cmp(pump_cfg, pump_m);
         cmp(pump_ua, {12'(pump_m[6:0] * 20), 12'(pump_m[13:7] * 20),
             10'(pump_m[20:14] * 5)});
         cmp({cp_offset_up_en, cp_offset_dn_en}, {pump_m[21], pump_m[22]});
         wr(ADDR_VCO_CAL, $urandom, 4'($urandom));
         rdchk(ADDR_VCO_CAL, {8'h00, cal_m});
         cmp({cal_enable, cal_force_curve}, {!cal_m[11], cal_m[10]});
      end
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_VCO_CAL, 32'(c) << 13, 4'hF);
         repeat (32) tick();
         k = n_ctick;
         repeat (64) tick();
         cmp(n_ctick - k, 64 / ratio[c]);
      end
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_VCO_CAL, 32'(c), 4'hF);
         cal_start <= 1'b1;
         @(posedge pclk);
         cal_start <= 1'b0;
         @(posedge pclk);
         m = 0;
         do begin
            tick();
            m++;
         end while (window_done !== 1'b1 && m < 300);
         cmp(m, 1 << c);
      end
      wr(ADDR_VCO_CAL, 32'h000800, 4'hF);
      cal_start <= 1'b1;
      @(posedge pclk);
      cal_start <= 1'b0;
      @(posedge pclk);
      cmp(window_busy, 1'b0);
      tick();
      cmp(window_done, 1'b0);
      for (int b = 0; b < 2; b++) begin
         wr(ADDR_VCO_CAL, b ? 32'h001000 : 32'h0, 4'hF);
         k = n_xfer;
         repeat (3) begin
            vco_access_wr <= 1'b1;
            @(posedge pclk);
            vco_access_wr <= 1'b0;
            @(posedge pclk);
         end
         @(posedge pclk);
         cmp(n_xfer - k, b ? 0 : 3);
      end
      rdchk(ADDR_STATUS, 32'h0000_0103);
      wr(ADDR_STATUS, 32'h0000_01FF, 4'h3);
      rdchk(ADDR_STATUS, 32'h0000_0000);
      // a second reset in mid-run must bring back the pump and calibration register defaults
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk_rst();
      finish_test();
   end
endmodule
`default_nettype wire
